// ===== rtl/dag_pkg.sv
// package for the data address generation block
package dag_pkg;
    localparam logic [15:0] DAG_ADDR_MAX = 16'hFFFF;
    localparam logic [15:0] DAG_PAGE0_MAX = 16'h7FFF;
    localparam logic [9:0] DAG_PAGE_RST = 10'h001;
    localparam logic [9:0] DAG_PAGE_ZERO = 10'h000;
    localparam logic [15:0] DAG_SP_RST = 16'h1000;
    localparam int DAG_WIN_BIT = 15;
    localparam int DAG_PS_BIT = 9;
    localparam logic [12:0] DAG_NEAR_MASK = 13'h1FFF;
    localparam logic [3:0] DAG_SP_IDX = 4'hF;
    localparam logic [3:0] DAG_FP_IDX = 4'hE;
    localparam logic [3:0] DAG_X_PTR_A = 4'h8;
    localparam logic [3:0] DAG_X_PTR_B = 4'h9;
    localparam logic [3:0] DAG_Y_PTR_A = 4'hA;
    localparam logic [3:0] DAG_Y_PTR_B = 4'hB;
    localparam logic [3:0] DAG_PTR_NONE = 4'h0;
    localparam logic [15:0] DAG_STEP_WORD = 16'h0002;
    localparam logic [9:0] DAG_REG_PAGE = 10'h000;

    // register bus: 0 = read page, 4 = stack pointer, 8 = status/trap
    localparam logic [3:0] DAG_REG_PAGE_OFS = 4'h0;
    localparam logic [3:0] DAG_REG_SP_OFS = 4'h4;
    localparam logic [3:0] DAG_REG_STAT_OFS = 4'h8;

    typedef enum logic [2:0] {
        DAG_MODE_FILE,
        DAG_MODE_DIRECT,
        DAG_MODE_IND,
        DAG_MODE_POST,
        DAG_MODE_PRE,
        DAG_MODE_INDEX,
        DAG_MODE_LIT_OFS,
        DAG_MODE_LIT
    } dag_mode_t;

    typedef enum logic [1:0] {
        DAG_MAC_IND,
        DAG_MAC_POST,
        DAG_MAC_INDEX
    } dag_mac_mode_t;

    typedef enum logic [1:0] {
        DAG_STK_NONE,
        DAG_STK_CALL,
        DAG_STK_EXC,
        DAG_STK_RET
    } dag_stk_t;

    typedef struct packed {
        logic valid;
        dag_mode_t mode;
        logic [3:0] ptr_sel;
        logic [3:0] ofs_sel;
        logic [15:0] lit;
        logic [12:0] file_addr;
        logic is_move;
        logic is_mac;
        dag_mac_mode_t mac_mode;
        logic [2:0] mac_step;
        logic step_down;
    } dag_req_t;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
        logic ps_read;
        logic trap;
        logic wb_en;
        logic [3:0] wb_sel;
        logic [15:0] wb_val;
    } dag_resp_t;
endpackage : dag_pkg

// ===== rtl/dag_core.sv
// data address generator: paging, stack pointer and effective address modes
//
// Behaviour
// RL1 - base addresses 0x0000..0x7FFF always reach page zero, whatever the page.
// RL2 - every reset loads the read page register with 0x001.
// RL3 - upper-window access with read page 0x000 raises an address error trap.
// RL4 - nonzero pages reached only with address bit 15 set plus read page.
// RL5 - register fifteen is the stack pointer, auto-updated, still writable by software.
// RL6 - stack pointer bit zero held at zero by hardware.
// RL7 - every reset sets the stack pointer to 0x1000.
// RL8 - stack grows upward: increment after push, decrement before pop.
// RL9 - push low PC word first, then bits 22..16; call zero-extends upper byte.
// RL10 - exception push merges upper PC byte with status low byte.
// RL11 - stack pointer and active frame pointer addresses are never paged.
// RL12 - file register instructions use 13-bit direct address; only move reaches all.
// RL13 - file register default working register is work register zero.
// RL14 - three-operand: operand one register direct, operand two register, memory or 5-bit literal.
// RL15 - post-modify uses pointer then adjusts; pre-modify adds signed constant first.
// RL16 - indexed adds pointer and offset register; literal offset adds literal.
// RL17 - move source and destination share one 4-bit offset register field.
// RL18 - move and accumulator add indexed mode and 8/16-bit literals.
// RL19 - dual-operand prefetch uses registers 8..11; 8,9 X unit, 10,11 Y unit.
// RL20 - dual-operand indexed only with register 9 in X and 11 in Y.
// RL21 - dual-operand modes: indirect, indexed, post-modify by 2, 4 or 6.
// RL22 - branch literal is 16-bit signed; interrupt hold literal 14-bit unsigned.
// RL23 - page bit 9 and address bit 15 give 24-bit program space read address.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dag_core
    import dag_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [15:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [15:0] REG_RDATA_OUT,
    input wire dag_req_t REQ_IN,
    input wire logic [15:0] WORK_REG_FILE_IN [16],
    input wire logic FRAME_ACTIVE_FLAG_IN,
    input wire dag_stk_t STK_OP_IN,
    input wire logic [22:0] PC_IN,
    input wire logic [7:0] STATUS_LOW_BYTE_IN,
    input wire logic [15:0] BRANCH_LIT_IN,
    input wire logic [13:0] HOLD_LIT_IN,
    output dag_resp_t RESP_OUT,
    output logic STK_WR_OUT,
    output logic [15:0] STK_ADDR_OUT,
    output logic [15:0] STK_DATA_OUT,
    output logic [15:0] STACK_PTR_OUT,
    output logic [22:0] BRANCH_TARGET_OUT,
    output logic [13:0] HOLD_COUNT_OUT,
    output logic ADDR_ERR_OUT
);

    // ==========================================================
    // functions
    function automatic logic [15:0] word_align(input logic [15:0] v);
        word_align = {v[15:1], 1'b0}; // [RL6]
    endfunction : word_align

    function automatic logic mac_ptr_ok(input logic [3:0] sel, input dag_mac_mode_t m);
        logic ok;
        ok = (sel == DAG_X_PTR_A) || (sel == DAG_X_PTR_B) ||
             (sel == DAG_Y_PTR_A) || (sel == DAG_Y_PTR_B); // [RL19]
        if (m == DAG_MAC_INDEX) begin
            ok = (sel == DAG_X_PTR_B) || (sel == DAG_Y_PTR_B); // [RL20]
        end
        mac_ptr_ok = ok;
    endfunction : mac_ptr_ok

    // ==========================================================
    // state
    logic [9:0] read_page_reg_ff;
    logic [15:0] stack_ptr_reg_ff;
    logic addr_err_ff;
    logic [1:0] push_phase_ff;
    logic [15:0] push_hi_ff;
    dag_resp_t resp_ff;
    logic [15:0] rdata_ff;
    logic stk_wr_ff;
    logic [15:0] stk_addr_ff;
    logic [15:0] stk_data_ff;
    logic [22:0] branch_ff;
    logic [13:0] hold_ff;

    // ==========================================================
    // effective address
    logic [15:0] ptr_val;
    logic [15:0] ofs_val;
    logic [15:0] step;
    logic [15:0] eff_addr;
    logic [15:0] nxt_ptr;
    logic wb;
    logic unpaged;
    logic mode_ok;
    logic [23:0] full_addr;
    logic ps_rd;
    logic trap;

    always_comb begin
        ptr_val = WORK_REG_FILE_IN[REQ_IN.ptr_sel];
        ofs_val = WORK_REG_FILE_IN[REQ_IN.ofs_sel]; // [RL17]
        step = REQ_IN.is_mac ? {12'h000, REQ_IN.mac_step, 1'b0} : REQ_IN.lit;
        eff_addr = ptr_val;
        nxt_ptr = ptr_val;
        wb = 1'b0;
        mode_ok = 1'b1;
        if (REQ_IN.is_mac) begin
            mode_ok = mac_ptr_ok(REQ_IN.ptr_sel, REQ_IN.mac_mode) &&
                      (REQ_IN.mac_mode != DAG_MAC_POST ||
                       REQ_IN.mac_step inside {3'd1, 3'd2, 3'd3}); // [RL21]
            case (REQ_IN.mac_mode)
                DAG_MAC_POST: begin
                    nxt_ptr = REQ_IN.step_down ? ptr_val - step : ptr_val + step; // [RL21]
                    wb = 1'b1;
                end
                DAG_MAC_INDEX: eff_addr = ptr_val + ofs_val; // [RL20]
                default: eff_addr = ptr_val;
            endcase
        end else begin
            case (REQ_IN.mode)
                DAG_MODE_FILE: begin
                    // near space unless move widens it
                    eff_addr = REQ_IN.is_move ? REQ_IN.lit : {3'b000, REQ_IN.file_addr & DAG_NEAR_MASK}; // [RL12]
                end
                DAG_MODE_POST: begin
                    eff_addr = ptr_val; // [RL15]
                    nxt_ptr = REQ_IN.step_down ? ptr_val - step : ptr_val + step;
                    wb = 1'b1;
                end
                DAG_MODE_PRE: begin
                    eff_addr = ptr_val + step; // [RL15]
                    nxt_ptr = eff_addr;
                    wb = 1'b1;
                end
                DAG_MODE_INDEX: begin
                    eff_addr = ptr_val + ofs_val; // [RL16]
                    mode_ok = REQ_IN.is_move; // [RL18]
                end
                DAG_MODE_LIT_OFS: eff_addr = ptr_val + REQ_IN.lit; // [RL16]
                DAG_MODE_LIT: eff_addr = REQ_IN.lit; // [RL14] [RL18]
                default: eff_addr = ptr_val;
            endcase
        end
        if (REQ_IN.ptr_sel == DAG_SP_IDX && wb) begin
            nxt_ptr = word_align(nxt_ptr); // [RL6]
        end
        unpaged = (REQ_IN.ptr_sel == DAG_SP_IDX) ||
                  (REQ_IN.ptr_sel == DAG_FP_IDX && FRAME_ACTIVE_FLAG_IN) ||
                  REQ_IN.mode == DAG_MODE_FILE || REQ_IN.mode == DAG_MODE_LIT ||
                  REQ_IN.mode == DAG_MODE_DIRECT; // [RL11]
        ps_rd = 1'b0;
        trap = 1'b0;
        if (!eff_addr[DAG_WIN_BIT] || unpaged) begin
            full_addr = {8'h00, eff_addr}; // [RL1] [RL11]
        end else begin
            full_addr = {read_page_reg_ff[8:0], eff_addr[14:0]}; // [RL4] [RL23]
            ps_rd = read_page_reg_ff[DAG_PS_BIT]; // [RL23]
            trap = (read_page_reg_ff == DAG_PAGE_ZERO); // [RL3]
        end
        if (!mode_ok) begin
            trap = 1'b1;
        end
    end

    // ==========================================================
    // response
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            resp_ff <= '0;
        end else begin
            resp_ff.valid <= REQ_IN.valid;
            resp_ff.addr <= full_addr;
            resp_ff.ps_read <= ps_rd;
            resp_ff.trap <= REQ_IN.valid && trap; // [RL3]
            // a trapped access never completes, so its pointer stays put
            resp_ff.wb_en <= REQ_IN.valid && wb && !trap && REQ_IN.ptr_sel != DAG_SP_IDX;
            // file register results go to work register zero by default
            resp_ff.wb_sel <= (REQ_IN.mode == DAG_MODE_FILE && !REQ_IN.is_mac) ? DAG_PTR_NONE : REQ_IN.ptr_sel; // [RL13]
            resp_ff.wb_val <= nxt_ptr;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            addr_err_ff <= 1'b0;
        end else if (REQ_IN.valid && trap) begin
            addr_err_ff <= 1'b1; // [RL3]  set wins over clear
        end else if (REG_WR_IN && REG_ADDR_IN == DAG_REG_STAT_OFS && REG_WDATA_IN[0]) begin
            addr_err_ff <= 1'b0;
        end
    end

    // ==========================================================
    // read page register
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            read_page_reg_ff <= DAG_PAGE_RST; // [RL2]
        end else if (REG_WR_IN && REG_ADDR_IN == DAG_REG_PAGE_OFS) begin
            read_page_reg_ff <= REG_WDATA_IN[9:0];
        end
    end

    // ==========================================================
    // stack pointer and pc push
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            stack_ptr_reg_ff <= DAG_SP_RST; // [RL7]
            push_phase_ff <= 2'b00;
            push_hi_ff <= 16'h0000;
            stk_wr_ff <= 1'b0;
            stk_addr_ff <= 16'h0000;
            stk_data_ff <= 16'h0000;
        end else begin
            stk_wr_ff <= 1'b0;
            if (push_phase_ff == 2'b01) begin
                // second word: upper pc bits
                stk_wr_ff <= 1'b1;
                stk_addr_ff <= stack_ptr_reg_ff;
                stk_data_ff <= push_hi_ff; // [RL9]
                stack_ptr_reg_ff <= stack_ptr_reg_ff + DAG_STEP_WORD; // [RL8]
                push_phase_ff <= 2'b00;
            end else if (STK_OP_IN == DAG_STK_CALL || STK_OP_IN == DAG_STK_EXC) begin
                stk_wr_ff <= 1'b1;
                stk_addr_ff <= stack_ptr_reg_ff; // [RL8]
                stk_data_ff <= PC_IN[15:0]; // [RL9]
                push_hi_ff <= (STK_OP_IN == DAG_STK_EXC) ?
                              {STATUS_LOW_BYTE_IN, 1'b0, PC_IN[22:16]} : // [RL10]
                              {9'h000, PC_IN[22:16]}; // [RL9]
                stack_ptr_reg_ff <= stack_ptr_reg_ff + DAG_STEP_WORD; // [RL5] [RL8]
                push_phase_ff <= 2'b01;
            end else if (STK_OP_IN == DAG_STK_RET) begin
                stack_ptr_reg_ff <= stack_ptr_reg_ff - (DAG_STEP_WORD + DAG_STEP_WORD); // [RL8]
            end else if (REG_WR_IN && REG_ADDR_IN == DAG_REG_SP_OFS) begin
                stack_ptr_reg_ff <= word_align(REG_WDATA_IN); // [RL5] [RL6]
            end else if (REQ_IN.valid && wb && !trap && REQ_IN.ptr_sel == DAG_SP_IDX) begin
                stack_ptr_reg_ff <= nxt_ptr; // [RL5] [RL6]
            end
        end
    end

    // ==========================================================
    // literal decode
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            branch_ff <= 23'h000000;
            hold_ff <= 14'h0000;
        end else begin
            branch_ff <= PC_IN + {{7{BRANCH_LIT_IN[15]}}, BRANCH_LIT_IN}; // [RL22]
            hold_ff <= HOLD_LIT_IN; // [RL22]
        end
    end

    // ==========================================================
    // register read port
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            rdata_ff <= 16'h0000;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                DAG_REG_PAGE_OFS: rdata_ff <= {6'h00, read_page_reg_ff};
                DAG_REG_SP_OFS: rdata_ff <= stack_ptr_reg_ff;
                DAG_REG_STAT_OFS: rdata_ff <= {15'h0000, addr_err_ff};
                default: rdata_ff <= 16'h0000;
            endcase
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign REG_RDATA_OUT = rdata_ff;
    assign RESP_OUT = resp_ff;
    assign STK_WR_OUT = stk_wr_ff;
    assign STK_ADDR_OUT = stk_addr_ff;
    assign STK_DATA_OUT = stk_data_ff;
    assign STACK_PTR_OUT = stack_ptr_reg_ff;
    assign BRANCH_TARGET_OUT = branch_ff;
    assign HOLD_COUNT_OUT = hold_ff;
    assign ADDR_ERR_OUT = addr_err_ff;

    // ==========================================================
    // checks
    page_reset_a: assert property (@(posedge CLK_SYS_IN) // [RL2]
        !RST_N_IN |=> read_page_reg_ff == DAG_PAGE_RST)
        else $error("read page not 0x001 after reset");
    sp_reset_a: assert property (@(posedge CLK_SYS_IN) // [RL7]
        !RST_N_IN |=> stack_ptr_reg_ff == DAG_SP_RST)
        else $error("stack pointer not 0x1000 after reset");
    sp_align_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RL6]
        stack_ptr_reg_ff[0] == 1'b0)
        else $error("stack pointer odd");
    page_zero_trap_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RL3]
        REQ_IN.valid && eff_addr[15] && !unpaged && read_page_reg_ff == DAG_PAGE_ZERO |=> resp_ff.trap)
        else $error("page zero upper access did not trap");
    low_window_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RL1]
        REQ_IN.valid && !eff_addr[15] |=> resp_ff.addr[23:16] == 8'h00)
        else $error("lower window was paged");
    push_pair_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RL9]
        push_phase_ff == 2'b00 && STK_OP_IN == DAG_STK_CALL |=>
        stk_wr_ff && stk_data_ff == $past(PC_IN[15:0]) ##1 stk_wr_ff && stk_data_ff[15:7] == 9'h000)
        else $error("call push format wrong");
    push_grow_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RL8]
        push_phase_ff == 2'b00 && STK_OP_IN == DAG_STK_EXC |=> ##1
        stack_ptr_reg_ff == $past(stack_ptr_reg_ff, 2) + 16'h0004)
        else $error("stack did not grow by two words");
    sp_unpaged_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RL11]
        REQ_IN.valid && REQ_IN.ptr_sel == DAG_SP_IDX |=> resp_ff.addr[23:16] == 8'h00)
        else $error("stack access was paged");
endmodule : dag_core
`default_nettype wire

// ===== tb/dag_core_test.sv
// self-checking testbench for the data address generator
`timescale 1ns/1ps
`default_nettype none
module dag_core_test;
    import dag_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    dag_req_t req = '0;
    logic [15:0] work_regs [16];
    logic fa_flag = 1'b0;
    dag_stk_t stk_op = DAG_STK_NONE;
    logic [22:0] pc = 23'h5ABCDE;
    logic [7:0] stat_low = 8'hC3;
    logic [15:0] br_lit = 16'h0000;
    logic [13:0] hold_lit = 14'h0000;
    dag_resp_t resp;
    logic stk_wr;
    logic [15:0] stk_addr;
    logic [15:0] stk_data;
    logic [15:0] sp_out;
    logic [22:0] br_tgt;
    logic [13:0] hold_cnt;
    logic addr_err;
    int n_fail = 0;
    int compares = 0;

    always #2.5 clk = ~clk;

    dag_core u_dag_core (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
        .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata), .REQ_IN(req),
        .WORK_REG_FILE_IN(work_regs),
        .FRAME_ACTIVE_FLAG_IN(fa_flag), .STK_OP_IN(stk_op), .PC_IN(pc), .STATUS_LOW_BYTE_IN(stat_low),
        .BRANCH_LIT_IN(br_lit), .HOLD_LIT_IN(hold_lit), .RESP_OUT(resp), .STK_WR_OUT(stk_wr),
        .STK_ADDR_OUT(stk_addr), .STK_DATA_OUT(stk_data), .STACK_PTR_OUT(sp_out),
        .BRANCH_TARGET_OUT(br_tgt), .HOLD_COUNT_OUT(hold_cnt), .ADDR_ERR_OUT(addr_err));

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask : reg_read

    function automatic dag_req_t mk(input dag_mode_t m, input logic [3:0] p, input logic [15:0] l);
        mk = '0;
        mk.valid = 1'b1;
        mk.mode = m;
        mk.ptr_sel = p;
        mk.lit = l;
    endfunction : mk

    // one request, answer looked at in its single valid cycle
    task automatic run(input dag_req_t r, input logic [23:0] exp_addr, input logic trap);
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk(resp.valid, 1'b1, "resp valid");
        chk(resp.trap, trap, "trap");
        if (!trap) begin
            chk(resp.addr, exp_addr, "address");
        end
    endtask : run

    task automatic ind_chk(input logic [3:0] p, input logic [15:0] w, input logic [23:0] exp_addr, input logic trap);
        @(posedge clk);
        work_regs[p] <= w;
        run(mk(DAG_MODE_IND, p, 16'h0000), exp_addr, trap);
    endtask : ind_chk

    task automatic push(input dag_stk_t op, input logic [15:0] hi);
        logic [15:0] sp0;
        sp0 = sp_out;
        @(posedge clk);
        stk_op <= op;
        @(posedge clk);
        stk_op <= DAG_STK_NONE;
        #1;
        chk(stk_wr, 1'b1, "low word write");
        chk(stk_addr, sp0, "low word addr");
        chk(stk_data, pc[15:0], "low word data");
        @(posedge clk);
        #1;
        chk(stk_wr, 1'b1, "high word write");
        chk(stk_addr, sp0 + 16'h0002, "high word addr");
        chk(stk_data, hi, "high word data");
        @(posedge clk);
        #1;
        chk(sp_out, sp0 + 16'h0004, "sp after push");
    endtask : push

    // ==========================================================
    // scenarios
    task automatic t_regs;
        reg_read(DAG_REG_PAGE_OFS, {6'h00, DAG_PAGE_RST}, "page reset");
        reg_read(DAG_REG_SP_OFS, DAG_SP_RST, "sp reset");
        chk(sp_out, DAG_SP_RST, "sp port reset");
        reg_read(4'hC, 16'h0000, "unmapped read");
        reg_write(4'hC, 16'hFFFF);
        reg_write(DAG_REG_SP_OFS, 16'h2345);
        reg_read(DAG_REG_SP_OFS, 16'h2344, "sp bit0 forced");
    endtask : t_regs

    task automatic t_stack;
        logic [15:0] sp0;
        push(DAG_STK_CALL, {9'h000, pc[22:16]});
        push(DAG_STK_EXC, {stat_low, 1'b0, pc[22:16]});
        sp0 = sp_out;
        @(posedge clk);
        stk_op <= DAG_STK_RET;
        @(posedge clk);
        stk_op <= DAG_STK_NONE;
        repeat (2) @(posedge clk);
        #1;
        chk(sp_out, sp0 - 16'h0004, "sp after pop");
    endtask : t_stack

    task automatic t_page;
        reg_write(DAG_REG_PAGE_OFS, 16'h0002);
        ind_chk(4'h3, 16'h1234, 24'h001234, 1'b0);
        ind_chk(4'h3, 16'h9234, 24'h011234, 1'b0);
        reg_write(DAG_REG_PAGE_OFS, 16'h0201);
        ind_chk(4'h3, 16'h8010, 24'h008010, 1'b0);
        chk(resp.ps_read, 1'b1, "program space read");
        reg_write(DAG_REG_PAGE_OFS, 16'h0000);
        ind_chk(4'h3, 16'h7FFF, 24'h007FFF, 1'b0);
        ind_chk(4'h3, 16'h8000, 24'h000000, 1'b1);
        chk(addr_err, 1'b1, "error flag");
        reg_read(DAG_REG_STAT_OFS, 16'h0001, "error status");
        reg_write(DAG_REG_STAT_OFS, 16'h0001);
        reg_read(DAG_REG_STAT_OFS, 16'h0000, "error cleared");
        reg_write(DAG_REG_PAGE_OFS, 16'h0002);
        reg_write(DAG_REG_SP_OFS, 16'h9000);
        ind_chk(DAG_SP_IDX, 16'h9000, 24'h009000, 1'b0);
        @(posedge clk);
        fa_flag <= 1'b1;
        ind_chk(DAG_FP_IDX, 16'h8800, 24'h008800, 1'b0);
        @(posedge clk);
        fa_flag <= 1'b0;
        ind_chk(DAG_FP_IDX, 16'h8800, 24'h010800, 1'b0);
        reg_write(DAG_REG_PAGE_OFS, 16'h0001);
    endtask : t_page

    task automatic t_modes;
        dag_req_t r;
        ind_chk(4'h3, 16'h0300, 24'h000300, 1'b0);
        run(mk(DAG_MODE_POST, 4'h3, 16'h0002), 24'h000300, 1'b0);
        chk({resp.wb_en, resp.wb_sel, resp.wb_val}, {5'h13, 16'h0302}, "post writeback");
        run(mk(DAG_MODE_PRE, 4'h3, 16'hFFFE), 24'h0002FE, 1'b0);
        chk(resp.wb_val, 16'h02FE, "pre writeback");
        run(mk(DAG_MODE_LIT_OFS, 4'h3, 16'h0010), 24'h000310, 1'b0);
        r = mk(DAG_MODE_INDEX, 4'h3, 16'h0000);
        r.ofs_sel = 4'h5;
        run(r, 24'h000000, 1'b1);
        chk(resp.wb_en, 1'b0, "refused writeback");
        r.is_move = 1'b1;
        run(r, 24'h000800, 1'b0);
        r = mk(DAG_MODE_FILE, 4'h7, 16'h0000);
        r.file_addr = 13'h1FFF;
        run(r, 24'h001FFF, 1'b0);
        chk(resp.wb_sel, 4'h0, "file default register");
        r.is_move = 1'b1;
        r.lit = 16'hF000;
        run(r, 24'h00F000, 1'b0);
    endtask : t_modes

    task automatic t_mac;
        dag_req_t r;
        r = mk(DAG_MODE_IND, DAG_X_PTR_A, 16'h0000);
        r.is_mac = 1'b1;
        r.mac_mode = DAG_MAC_POST;
        r.mac_step = 3'h3;
        run(r, 24'h000800, 1'b0);
        chk(resp.wb_val, 16'h0806, "mac post step");
        r.mac_mode = DAG_MAC_IND;
        r.ptr_sel = DAG_Y_PTR_B;
        run(r, 24'h000B00, 1'b0);
        r.ptr_sel = 4'h3;
        run(r, 24'h000000, 1'b1);
        r.mac_mode = DAG_MAC_INDEX;
        r.ptr_sel = DAG_X_PTR_A;
        run(r, 24'h000000, 1'b1);
        r.ptr_sel = DAG_Y_PTR_A;
        run(r, 24'h000000, 1'b1);
    endtask : t_mac

    task automatic t_branch;
        @(posedge clk);
        br_lit <= 16'hFF00;
        hold_lit <= 14'h3FFF;
        repeat (2) @(posedge clk);
        #1;
        chk(br_tgt, 23'h5ABBDE, "branch target");
        chk(hold_cnt, 14'h3FFF, "hold count");
    endtask : t_branch

    // ==========================================================
    // main sequence and watchdog
    initial begin
        for (int i = 0; i < 16; i++) begin
            work_regs[i] = 16'(i * 256);
        end
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_stack;
        t_page;
        t_modes;
        t_mac;
        t_branch;
        finish_test;
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        #(20000 * 5);
        n_fail++;
        $display("ERROR t=%0t watchdog expired", $time);
        finish_test;
    end
endmodule : dag_core_test
`default_nettype wire
